// File: rtl/sarrd_buffer.v
// Purpose: two-entry buffer for finished samples
// Assumes: single clock, clock enable freezes state
// Notes: ready is honest full, valid is honest empty
`timescale 1ns/1ps
module sarrd_buffer (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        in_valid,
   output wire        in_ready,
   input  wire [11:0] in_data,
   output wire        out_valid,
   input  wire        out_ready,
   output wire [11:0] out_data
);
   reg [11:0] mem [0:1];
   reg        wr_ptr;
   reg        rd_ptr;
   reg [1:0]  count;
   wire       push;
   wire       pop;
   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
         mem[0] <= 12'h000;
         mem[1] <= 12'h000;
      end else if (ce) begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push & ~pop) begin
            count <= count + 2'h1;
         end else if (pop & ~push) begin
            count <= count - 2'h1;
         end
      end
   end
endmodule // sarrd_buffer

// File: rtl/sarrd_defines.vh
// Purpose: constants for the serial sample readout block
// Assumes: core_clk at 10 MHz, serial clock sampled as a plain input
// Notes: contract list below
`ifndef SARRD_DEFINES_VH
`define SARRD_DEFINES_VH
// ===========================================
// frame figures
`define SARRD_RES_BITS     5'h0c
`define SARRD_LEAD_ZEROS   5'h03
`define SARRD_FRAME_FALLS  5'h10
`define SARRD_TRACK_RISE   5'h0d
`define SARRD_SHDN_FIRST   5'h02
`define SARRD_SHDN_LAST    5'h09
`define SARRD_CNT_RESET    5'h00
`define SARRD_SAMPLE_RESET 12'h000
// ===========================================
// timing
`define SARRD_CLK_NS       100
`define SARRD_ACQ_NS       350
`define SARRD_QUIET_NS     50
`define SARRD_ACQ_CYC      ((`SARRD_ACQ_NS + `SARRD_CLK_NS - 1) / `SARRD_CLK_NS)
`endif

// File: rtl/sarrd_readout.v
// Purpose: device-side serial readout and sequencing of a 12-bit sampling converter
// Assumes: serial clock and chip select sampled by core_clk, far slower than it
// Notes: the result word enters from the core through a two-entry buffer
`timescale 1ns/1ps
`include "sarrd_defines.vh"
module sarrd_readout (
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire        ce,
   input  wire        cs_n_pin,
   input  wire        sclk_pin,
   output reg         serial_data_out,
   output reg         serial_data_oe_n,
   input  wire        sample_valid,
   output wire        sample_ready,
   input  wire [11:0] sample_data,
   output reg         hold_mode,
   output reg         shutdown,
   output reg         conv_start,
   output reg         conv_abort,
   output reg         frame_done,
   output reg         first_after_wake
);
   // ===========================================
   // reset release
   reg        rst_s1;
   reg        rst_n_i;
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1  <= 1'b0;
         rst_n_i <= 1'b0;
      end else begin
         rst_s1  <= 1'b1;
         rst_n_i <= rst_s1;
      end
   end
   // ===========================================
   // pin synchronisers and edge detect
   // two flops per pin; edges come from the second flop and its delayed copy
   // serial clock edges are ignored while chip select is high, so stray clocks move nothing
   reg        cs_s1;
   reg        cs_s2;
   reg        cs_d;
   reg        sck_s1;
   reg        sck_s2;
   reg        sck_d;
   wire       cs_fall;
   wire       cs_rise;
   wire       sck_fall;
   wire       sck_rise;
   always @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_d   <= 1'b1;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_d  <= 1'b1;
      end else if (ce) begin
         cs_s1  <= cs_n_pin;
         cs_s2  <= cs_s1;
         cs_d   <= cs_s2;
         sck_s1 <= sclk_pin;
         sck_s2 <= sck_s1;
         sck_d  <= sck_s2;
      end
   end
   assign cs_fall  = cs_d & ~cs_s2;
   assign cs_rise  = ~cs_d & cs_s2;
   assign sck_fall = sck_d & ~sck_s2 & ~cs_s2;
   assign sck_rise = ~sck_d & sck_s2 & ~cs_s2;
   // ===========================================
   // buffer between core and shifter
   // the word is popped on the edge that starts a frame, so a later push waits a frame
   wire        buf_valid;
   wire [11:0] buf_data;
   reg         buf_take;
   sarrd_buffer u_buf (
      .clk       (core_clk),
      .rst_n     (rst_n_i),
      .ce        (ce),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_data),
      .out_valid (buf_valid),
      .out_ready (buf_take),
      .out_data  (buf_data)
   );
   // ===========================================
   // frame sequencer
   localparam ST_IDLE  = 2'h0;
   localparam ST_FRAME = 2'h1;
   localparam ST_DONE  = 2'h2;
   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [4:0]  fall_cnt;
   reg [4:0]  rise_cnt;
   reg [11:0] shift;
   reg        was_shutdown;
   // ===========================================
   // frame events used only by the mode tracker; the sequencer decodes its own
   // a rise before the second fall is taken as noise and leaves the mode alone
   wire       frame_start;
   wire       wake_fall;
   wire       shdn_rise;
   assign frame_start = (state == ST_IDLE) & cs_fall;
   assign wake_fall   = (state == ST_FRAME) & sck_fall & (fall_cnt == `SARRD_SHDN_LAST);
   assign shdn_rise   = (state == ST_FRAME) & cs_rise & (fall_cnt >= `SARRD_SHDN_FIRST)
                        & (fall_cnt <= `SARRD_SHDN_LAST);
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cs_fall) begin
               next_state = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (cs_rise) begin
               next_state = ST_IDLE;
            end else if (sck_fall && fall_cnt == `SARRD_FRAME_FALLS - 5'h01) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // extra clocks of a long frame are ignored here
            if (cs_rise) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end
   always @* begin
      buf_take = (state == ST_IDLE) & cs_fall & buf_valid;
   end
   always @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state            <= ST_IDLE;
         fall_cnt         <= `SARRD_CNT_RESET;
         rise_cnt         <= `SARRD_CNT_RESET;
         shift            <= `SARRD_SAMPLE_RESET;
         serial_data_out  <= 1'b0;
         serial_data_oe_n <= 1'b1;
         hold_mode        <= 1'b0;
         conv_start       <= 1'b0;
         conv_abort       <= 1'b0;
         frame_done       <= 1'b0;
      end else if (ce) begin
         state      <= next_state;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         frame_done <= 1'b0;
         if (state == ST_IDLE && cs_fall) begin
            // sample taken now; an empty buffer yields a zero code
            shift            <= buf_valid ? buf_data : `SARRD_SAMPLE_RESET;
            hold_mode        <= 1'b1;
            serial_data_oe_n <= 1'b0;
            serial_data_out  <= 1'b0;
            fall_cnt         <= `SARRD_CNT_RESET;
            rise_cnt         <= `SARRD_CNT_RESET;
            conv_start       <= 1'b1;
         end else if (state != ST_IDLE) begin
            if (sck_rise) begin
               rise_cnt <= rise_cnt + 5'h01;
               if (rise_cnt == `SARRD_TRACK_RISE - 5'h01) begin
                  hold_mode <= 1'b0;
               end
            end
            if (sck_fall && state == ST_FRAME) begin
               fall_cnt <= fall_cnt + 5'h01;
               // launch bit for slot fall_cnt+1 on this falling edge
               if (fall_cnt < `SARRD_LEAD_ZEROS - 5'h01) begin
                  serial_data_out <= 1'b0;
               end else if (fall_cnt < `SARRD_LEAD_ZEROS + `SARRD_RES_BITS - 5'h01) begin
                  serial_data_out <= shift[11];
                  shift           <= {shift[10:0], 1'b0};
               end else begin
                  serial_data_out <= 1'b0;
               end
               if (fall_cnt == `SARRD_FRAME_FALLS - 5'h01) begin
                  serial_data_oe_n <= 1'b1;
                  serial_data_out  <= 1'b0;
                  frame_done       <= 1'b1;
               end
            end
            if (cs_rise) begin
               serial_data_oe_n <= 1'b1;
               serial_data_out  <= 1'b0;
               hold_mode        <= 1'b0;
               if (state == ST_FRAME && fall_cnt >= `SARRD_SHDN_FIRST) begin
                  conv_abort <= 1'b1;
               end
            end
         end
      end
   end
   // ===========================================
   // power mode tracking
   // power-up counts as a wake, so the first frame is flagged as well
   always @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shutdown         <= 1'b0;
         was_shutdown     <= 1'b1;
         first_after_wake <= 1'b0;
      end else if (ce) begin
         if (frame_start) begin
            // a frame cut before the tenth fall leaves shutdown set, so this flags again
            first_after_wake <= was_shutdown | shutdown;
            was_shutdown     <= 1'b0;
         end
         if (wake_fall) begin
            shutdown <= 1'b0;
         end else if (shdn_rise) begin
            shutdown     <= 1'b1;
            was_shutdown <= 1'b1;
         end
      end
   end
endmodule // sarrd_readout

// File: verif/sarrd_host.sv
// Purpose: host model for the readout link
// Assumes: 800 ns serial clock idling high
// Notes: a released line shows the inverse of the last bit
`timescale 1ns/1ps
module sarrd_host (
   input  wire        core_clk,
   input  wire        serial_data_out,
   input  wire        serial_data_oe_n,
   output reg         cs_n = 1'b1,
   output reg         sclk = 1'b1,
   output reg         rx_strobe = 1'b0,
   output reg  [15:0] rx_word = 16'h0000
);
   reg  last = 1'b0;
   wire sd   = serial_data_oe_n ? ~last : serial_data_out;
   always @(posedge core_clk) if (!serial_data_oe_n) last <= serial_data_out;
   // ===========================================
   // one frame of n serial clocks
   task frame(input integer n);
      integer k;
      begin
         @(posedge core_clk);
         #37 cs_n = 1'b0;
         for (k = 1; k <= n; k = k + 1) begin
            #400 sclk = 1'b0;
            if (k <= 16) rx_word = {rx_word[14:0], sd};
            #400 sclk = 1'b1;
         end
         #400 cs_n = 1'b1;
         rx_strobe = (n >= 16);
         // long gap covers acquisition, quiet time and padding
         #1600 rx_strobe = 1'b0;
      end
   endtask
endmodule // sarrd_host

// File: verif/sarrd_readout_chk.sv
// Purpose: assertions on the readout ports
// Assumes: slow serial clock
// Notes: bound below
`timescale 1ns/1ps
module sarrd_chk (
   input wire core_clk,
   input wire arst_n,
   input wire cs_n_pin,
   input wire sclk_pin,
   input wire serial_data_out,
   input wire serial_data_oe_n,
   input wire hold_mode,
   input wire shutdown,
   input wire conv_start,
   input wire conv_abort,
   input wire frame_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_start_late: assert property ($fell(cs_n_pin) |-> ##[2:6] conv_start)
      else $error("start late");
   a_start_drive: assert property (conv_start |->
      !serial_data_oe_n && hold_mode && !serial_data_out) else $error("start");
   a_hold_track: assert property ($fell(hold_mode) && !cs_n_pin |-> sclk_pin)
      else $error("track");
   a_bit_on_fall: assert property ($changed(serial_data_out) && !serial_data_oe_n
      && !conv_start |-> !sclk_pin || !$past(sclk_pin, 4)) else $error("bit");
   a_done_off: assert property (frame_done |-> serial_data_oe_n)
      else $error("done");
   a_cs_off: assert property ($rose(cs_n_pin) |-> ##[2:6] serial_data_oe_n)
      else $error("cs off");
   a_last_low: assert property (frame_done |-> !$past(serial_data_out))
      else $error("pad");
   a_shdn_cs: assert property ($rose(shutdown) |-> cs_n_pin)
      else $error("shdn");
   a_abort_off: assert property (conv_abort |-> serial_data_oe_n)
      else $error("abort");
endmodule // sarrd_chk
bind sarrd_readout sarrd_chk sarrd_chk_i (.core_clk(core_clk), .arst_n(arst_n),
   .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .serial_data_out(serial_data_out),
   .serial_data_oe_n(serial_data_oe_n), .hold_mode(hold_mode), .shutdown(shutdown),
   .conv_start(conv_start), .conv_abort(conv_abort), .frame_done(frame_done));

// File: verif/test_serial_adc_sample_readout.sv
// Purpose: bench for the readout block
// Assumes: host model drives the link
// Notes: results checked in order from a queue
`timescale 1ns/1ps
module test_serial_adc_sample_readout;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         vld = 1'b0;
   reg  [11:0] dat = 12'h000;
   reg  [11:0] w;
   reg  [15:0] exp_q [$];
   integer     seed = 65;
   integer     n_fail = 0;
   integer     checks = 0;
   integer     i;
   integer     n_start = 0;
   integer     n_abort = 0;
   integer     n_done = 0;
   reg         ce = 1'b1;
   wire        cs_n, sclk, stb, sdo, oe_n, rdy, shdn;
   wire        hold, cstart, cabort, fdone, faw;
   wire [15:0] rx;
   always #50 clk = ~clk;
   sarrd_readout sarrd_readout_i (.core_clk(clk), .arst_n(rst_n), .ce(ce),
      .cs_n_pin(cs_n), .sclk_pin(sclk), .serial_data_out(sdo), .serial_data_oe_n(oe_n),
      .sample_valid(vld), .sample_ready(rdy), .sample_data(dat), .hold_mode(hold),
      .shutdown(shdn), .conv_start(cstart), .conv_abort(cabort), .frame_done(fdone),
      .first_after_wake(faw));
   sarrd_host sarrd_host_i (.core_clk(clk), .serial_data_out(sdo),
      .serial_data_oe_n(oe_n), .cs_n(cs_n), .sclk(sclk), .rx_strobe(stb), .rx_word(rx));
   task check(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task push(input [11:0] d);
      begin
         @(posedge clk);
         vld <= 1'b1;
         dat <= d;
         @(posedge clk);
         vld <= 1'b0;
         exp_q.push_back({3'b000, d, 1'b0});
      end
   endtask
   always @(posedge stb) check(rx, exp_q.size() ? exp_q.pop_front() : ~rx);
   // pulse counters, compared with the number of frames of each kind at the end
   always @(posedge clk) begin
      if (cstart) n_start <= n_start + 1;
      if (cabort) n_abort <= n_abort + 1;
      if (fdone) n_done <= n_done + 1;
   end
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      w = 12'($random(seed));
      push(w);
      push(~w);
      #1 check({15'h0000, rdy}, 16'h0000);
      // a word offered while full must be dropped
      @(posedge clk);
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      sarrd_host_i.frame(16);
      check({15'h0000, faw}, 16'h0001);
      check({15'h0000, hold}, 16'h0000);
      sarrd_host_i.frame(20);
      check({15'h0000, faw}, 16'h0000);
      exp_q.push_back(16'h0000);
      sarrd_host_i.frame(16);
      check({15'h0000, oe_n}, 16'h0001);
      sarrd_host_i.frame(5);
      check({15'h0000, shdn}, 16'h0001);
      sarrd_host_i.frame(1);
      check({15'h0000, shdn}, 16'h0001);
      check({15'h0000, faw}, 16'h0001);
      sarrd_host_i.frame(12);
      check({15'h0000, shdn}, 16'h0000);
      check({15'h0000, faw}, 16'h0001);
      // clock enable low: the offered word is frozen out, so the frame reads zero
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      vld <= 1'b1;
      dat <= 12'($random(seed));
      @(posedge clk);
      vld <= 1'b0;
      ce <= 1'b1;
      exp_q.push_back(16'h0000);
      sarrd_host_i.frame(16);
      for (i = 0; i < 4; i = i + 1) begin
         w = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($random(seed));
         push(w);
         sarrd_host_i.frame(16);
         check({15'h0000, faw}, 16'h0000);
      end
      check(n_start[15:0], 16'h000b);
      check(n_abort[15:0], 16'h0002);
      check(n_done[15:0], 16'h0008);
      end_of_test;
   end
endmodule // test_serial_adc_sample_readout
